// file: eth_port_regs.svh
`ifndef ETH_PORT_REGS_SVH
`define ETH_PORT_REGS_SVH

// ==========================================================================
// Clock and timing
`define CLK_SYS_PERIOD_NS 8
`define MDC_MIN_PERIOD_NS 400
`define MDC_HALF_CYCLES ((`MDC_MIN_PERIOD_NS / 2 + `CLK_SYS_PERIOD_NS - 1) / `CLK_SYS_PERIOD_NS)
`define LINK_MIN_PERIOD_NS 16
`define LINK_HALF_CYCLES ((`LINK_MIN_PERIOD_NS / 2 + `CLK_SYS_PERIOD_NS - 1) / `CLK_SYS_PERIOD_NS)

// ==========================================================================
// Management frame layout
`define MDIO_FRAME_BITS 7'd64
`define MDIO_TA_BIT 7'd46
`define MDIO_DATA_BIT 7'd48
`define MDIO_PREAMBLE 32'hffff_ffff
`define MDIO_START 2'h1
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_TA_WRITE 2'h2

// ==========================================================================
// Buffering and reset values
`define TX_FIFO_DEPTH 8
`define TX_FIFO_WIDTH 8
`define SUPPLY_ON_RESET 1'b1

`endif

// file: eth_port_pkg.sv
package eth_port_pkg;

    // ======================================================================
    // Modes and states
    typedef enum logic [1:0] {
        MODE_RGMII = 2'b01,
        MODE_RMII = 2'b10
    } link_mode_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } tx_state_t;

    typedef enum logic [1:0] {
        MG_IDLE = 2'b01,
        MG_RUN = 2'b10
    } mg_state_t;

    // ======================================================================
    // State of the port apart from the transmit buffer
    typedef struct packed {
        link_mode_t mode;
        tx_state_t tx;
        mg_state_t mg;
        logic [7:0] link_cnt;
        logic link_clk;
        logic [7:0] tx_byte;
        logic [1:0] tx_idx;
        logic tx_ctl;
        logic [3:0] txd;
        logic [2:0] rxc_s;
        logic [1:0] rxctl_s;
        logic [3:0] rxd_s1;
        logic [3:0] rxd_s2;
        logic rx_dv_lo;
        logic [3:0] rx_lo;
        logic [7:0] rx_shift;
        logic [1:0] rx_idx;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_err;
        logic rx_active;
        logic [1:0] irq_s;
        logic irq_pending;
        logic [7:0] mdc_cnt;
        logic mdc;
        logic [63:0] mg_shift;
        logic [6:0] mg_bit;
        logic mg_read;
        logic mg_oe_n;
        logic mg_out;
        logic [1:0] mdio_s;
        logic [15:0] mg_rdata;
        logic mg_done;
        logic mg_busy;
        logic supply;
    } port_state_t;

endpackage : eth_port_pkg

// file: tx_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Fill side
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    // Drain side
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("tx_fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic not_full;
        logic not_empty;
    } fifo_state_t;

    fifo_state_t st_q;
    fifo_state_t st_d;
    logic push;
    logic pop;

    assign push = wr_valid & st_q.not_full;
    assign pop = rd_ready & st_q.not_empty;
    assign wr_ready = st_q.not_full;
    assign rd_valid = st_q.not_empty;
    assign rd_data = st_q.mem[st_q.rp];

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wp] = wr_data;
            st_d.wp = st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        st_d.not_full = (st_d.cnt != (AW + 1)'(DEPTH));
        st_d.not_empty = (st_d.cnt != '0);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.not_full <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : tx_fifo

`default_nettype wire

// file: eth_phy_port.sv
// Notes on behaviour
// RQ1: Link runs up to gigabit class rate over the reduced gigabit link; here the link clock is at most clk_sys/2, 500 Mbit/s in RGMII.
// RQ2: In RGMII mode the port generates and drives the transmit clock.
// RQ3: In RMII mode the same pin drives the reference clock out.
// RQ4: RGMII transmit control updates on both edges of the transmit clock.
// RQ5: RMII transmit enable changes aligned to the driven reference clock.
// RQ6: Receive clock comes from the PHY; RGMII capture follows its edges.
// RQ7: RGMII receive control captured on both receive clock edges.
// RQ8: RMII receive control pin carries combined carrier sense and data valid.
// RQ9: Four transmit data bits in RGMII; bits 2 and 3 RGMII only.
// RQ10: RMII uses only transmit data bits 0 and 1.
// RQ11: Four receive bits in RGMII, only bits 0 and 1 in RMII.
// RQ12: High level on PHY interrupt input means a pending PHY interrupt.
// RQ13: Port generates the management clock toward the PHY.
// RQ14: Management data driven while sending, released while receiving.
// RQ15: Link mode is static and only changes while the port is idle.
`timescale 1ns/1ns
`default_nettype none
`include "eth_port_regs.svh"

module eth_phy_port
    import eth_port_pkg::*;
#(
    parameter int LINK_HALF = `LINK_HALF_CYCLES,
    parameter int MDC_HALF = `MDC_HALF_CYCLES,
    parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Configuration
    input wire logic mode_rmii_sel,
    output logic mode_is_rmii,
    // Transmit byte stream
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // Receive byte stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_err,
    output logic rx_active,
    // Management command port
    input wire logic mgmt_start,
    input wire logic mgmt_read,
    input wire logic [4:0] mgmt_phy_addr,
    input wire logic [4:0] mgmt_reg_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_busy,
    output logic mgmt_done,
    // PHY transmit pins
    output logic mac_tx_clock_pin,
    output logic mac_tx_control_pin,
    output logic mac_tx_data_bit0,
    output logic mac_tx_data_bit1,
    output logic mac_tx_data_bit2,
    output logic mac_tx_data_bit3,
    // PHY receive pins
    input wire logic phy_rx_clock_pin,
    input wire logic phy_rx_control_pin,
    input wire logic phy_rx_data_bit0,
    input wire logic phy_rx_data_bit1,
    input wire logic phy_rx_data_bit2,
    input wire logic phy_rx_data_bit3,
    // PHY management and misc pins
    output logic mgmt_clock_pin,
    input wire logic mgmt_data_in,
    output logic mgmt_data_out,
    output logic mgmt_data_oe_n,
    input wire logic phy_interrupt_in,
    output logic phy_irq_pending,
    output logic port_supply_out
);

    // ======================================================================
    // Elaboration checks
    if (LINK_HALF < 1 || LINK_HALF > 255) begin : g_bad_link
        $error("LINK_HALF must be 1 to 255");
    end
    // Read bit must clear the synchroniser before the clock rise
    if (MDC_HALF < 3 || MDC_HALF > 255) begin : g_bad_mdc
        $error("MDC_HALF must be 3 to 255");
    end

    localparam logic [7:0] LINK_LAST = 8'(LINK_HALF - 1);
    localparam logic [7:0] MDC_LAST = 8'(MDC_HALF - 1);

    port_state_t st_q;
    port_state_t st_d;

    logic fifo_valid;
    logic [7:0] fifo_data;
    logic fifo_pop;

    // ======================================================================
    // Transmit buffer
    tx_fifo #(
        .WIDTH(`TX_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_valid(tx_valid),
        .wr_ready(tx_ready),
        .wr_data(tx_data),
        .rd_valid(fifo_valid),
        .rd_ready(fifo_pop),
        .rd_data(fifo_data)
    );

    // ======================================================================
    // Next state
    logic link_tick;
    logic link_rise;
    logic link_fall;
    logic rgmii;
    logic tx_start;
    logic rxc_rise;
    logic rxc_fall;
    logic mdc_tick;
    logic mdc_rise;
    logic mdc_fall;
    logic port_idle;

    always_comb begin
        st_d = st_q;
        rgmii = (st_q.mode == MODE_RGMII);
        st_d.rx_valid = 1'b0;
        st_d.mg_done = 1'b0;

        // RQ1: link clock divider
        link_tick = (st_q.link_cnt == LINK_LAST);
        link_rise = link_tick & ~st_q.link_clk;
        link_fall = link_tick & st_q.link_clk;
        st_d.link_cnt = link_tick ? 8'h00 : st_q.link_cnt + 8'h01;
        // RQ2: transmit or reference clock out
        if (link_tick) begin
            st_d.link_clk = ~st_q.link_clk;
        end

        // Input synchronisers
        st_d.rxc_s = {st_q.rxc_s[1:0], phy_rx_clock_pin};
        st_d.rxctl_s = {st_q.rxctl_s[0], phy_rx_control_pin};
        st_d.rxd_s1 = {phy_rx_data_bit3, phy_rx_data_bit2, phy_rx_data_bit1, phy_rx_data_bit0};
        st_d.rxd_s2 = st_q.rxd_s1;
        st_d.irq_s = {st_q.irq_s[0], phy_interrupt_in};
        st_d.mdio_s = {st_q.mdio_s[0], mgmt_data_in};

        // RQ12: interrupt pending level
        st_d.irq_pending = st_q.irq_s[1];

        // Transmit path
        tx_start = rgmii ? link_rise : (link_fall && st_q.tx_idx == 2'h0);
        fifo_pop = tx_start & fifo_valid;
        if (tx_start) begin
            if (fifo_valid) begin
                st_d.tx = TX_SEND;
                st_d.tx_byte = fifo_data;
                // RQ4: control set with clock rise in RGMII, with clock fall in RMII
                st_d.tx_ctl = 1'b1;
                if (rgmii) begin
                    // RQ9: low nibble on four bits
                    st_d.txd = fifo_data[3:0];
                    st_d.tx_idx = 2'h0;
                end else begin
                    // RQ10: first dibit, upper bits idle
                    st_d.txd = {2'b00, fifo_data[1:0]};
                    st_d.tx_idx = 2'h1;
                end
            end else begin
                st_d.tx = TX_IDLE;
                st_d.tx_ctl = 1'b0;
                st_d.txd = 4'h0;
                st_d.tx_idx = 2'h0;
            end
        end else if (st_q.tx == TX_SEND && link_fall) begin
            if (rgmii) begin
                // RQ4: second half with clock fall
                st_d.txd = st_q.tx_byte[7:4];
                st_d.tx_ctl = 1'b1;
            end else begin
                // RQ5: next dibit on reference fall, enable held
                st_d.txd = {2'b00, st_q.tx_byte[{st_q.tx_idx, 1'b0} +: 2]};
                st_d.tx_idx = st_q.tx_idx + 2'h1;
            end
        end

        // RQ6: edges of the PHY receive clock
        rxc_rise = st_q.rxc_s[1] & ~st_q.rxc_s[2];
        rxc_fall = ~st_q.rxc_s[1] & st_q.rxc_s[2];
        if (rgmii) begin
            // RQ7: control and low nibble on rise
            if (rxc_rise) begin
                st_d.rx_dv_lo = st_q.rxctl_s[1];
                st_d.rx_lo = st_q.rxd_s2;
                st_d.rx_active = st_q.rxctl_s[1];
            end
            // RQ11: high nibble completes the byte
            if (rxc_fall && st_q.rx_dv_lo) begin
                st_d.rx_data = {st_q.rxd_s2, st_q.rx_lo};
                st_d.rx_err = ~st_q.rxctl_s[1];
                st_d.rx_valid = 1'b1;
            end
        end else if (link_rise) begin
            // RQ8: carrier sense and data valid
            if (st_q.rxctl_s[1]) begin
                st_d.rx_active = 1'b1;
                st_d.rx_shift = {st_q.rxd_s2[1:0], st_q.rx_shift[7:2]};
                st_d.rx_idx = st_q.rx_idx + 2'h1;
                // RQ11: four dibits per byte
                if (st_q.rx_idx == 2'h3) begin
                    st_d.rx_data = {st_q.rxd_s2[1:0], st_q.rx_shift[7:2]};
                    st_d.rx_err = 1'b0;
                    st_d.rx_valid = 1'b1;
                end
            end else begin
                st_d.rx_active = 1'b0;
                st_d.rx_idx = 2'h0;
            end
        end

        // RQ13: management clock divider
        mdc_tick = (st_q.mdc_cnt == MDC_LAST);
        mdc_rise = mdc_tick & ~st_q.mdc;
        mdc_fall = mdc_tick & st_q.mdc;
        st_d.mdc_cnt = mdc_tick ? 8'h00 : st_q.mdc_cnt + 8'h01;
        if (mdc_tick) begin
            st_d.mdc = ~st_q.mdc;
        end

        // Management frame engine
        case (st_q.mg)
            MG_IDLE: begin
                if (mgmt_start) begin
                    st_d.mg = MG_RUN;
                    st_d.mg_busy = 1'b1;
                    st_d.mg_read = mgmt_read;
                    st_d.mg_bit = 7'h00;
                    st_d.mg_shift = {`MDIO_PREAMBLE, `MDIO_START,
                        mgmt_read ? `MDIO_OP_READ : `MDIO_OP_WRITE,
                        mgmt_phy_addr, mgmt_reg_addr,
                        `MDIO_TA_WRITE, mgmt_read ? 16'h0000 : mgmt_wdata};
                end
            end
            MG_RUN: begin
                if (mdc_fall) begin
                    if (st_q.mg_bit == `MDIO_FRAME_BITS) begin
                        st_d.mg = MG_IDLE;
                        st_d.mg_busy = 1'b0;
                        st_d.mg_done = 1'b1;
                        st_d.mg_oe_n = 1'b1;
                    end else begin
                        // RQ14: release from turnaround on reads
                        st_d.mg_oe_n = st_q.mg_read && st_q.mg_bit >= `MDIO_TA_BIT;
                        st_d.mg_out = st_q.mg_shift[63];
                        st_d.mg_shift = {st_q.mg_shift[62:0], 1'b0};
                        st_d.mg_bit = st_q.mg_bit + 7'h01;
                    end
                end
                if (mdc_rise && st_q.mg_read && st_q.mg_bit > `MDIO_DATA_BIT) begin
                    st_d.mg_rdata = {st_q.mg_rdata[14:0], st_q.mdio_s[1]};
                end
            end
            default: begin
                st_d.mg = MG_IDLE;
                st_d.mg_busy = 1'b0;
                st_d.mg_oe_n = 1'b1;
            end
        endcase

        // RQ15: mode taken only while idle
        port_idle = (st_q.tx == TX_IDLE) && !fifo_valid && !st_q.rx_active
            && !st_q.rxctl_s[1];
        if (port_idle) begin
            st_d.mode = mode_rmii_sel ? MODE_RMII : MODE_RGMII;
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.mode <= MODE_RGMII;
            st_q.tx <= TX_IDLE;
            st_q.mg <= MG_IDLE;
            st_q.mg_oe_n <= 1'b1;
            st_q.supply <= `SUPPLY_ON_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // Outputs
    assign mode_is_rmii = st_q.mode[1];
    assign rx_data = st_q.rx_data;
    assign rx_valid = st_q.rx_valid;
    assign rx_err = st_q.rx_err;
    assign rx_active = st_q.rx_active;
    assign mgmt_rdata = st_q.mg_rdata;
    assign mgmt_busy = st_q.mg_busy;
    assign mgmt_done = st_q.mg_done;
    assign mac_tx_clock_pin = st_q.link_clk;
    assign mac_tx_control_pin = st_q.tx_ctl;
    assign mac_tx_data_bit0 = st_q.txd[0];
    assign mac_tx_data_bit1 = st_q.txd[1];
    assign mac_tx_data_bit2 = st_q.txd[2];
    assign mac_tx_data_bit3 = st_q.txd[3];
    assign mgmt_clock_pin = st_q.mdc;
    assign mgmt_data_out = st_q.mg_out;
    assign mgmt_data_oe_n = st_q.mg_oe_n;
    assign phy_irq_pending = st_q.irq_pending;
    assign port_supply_out = st_q.supply;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_irq_held;
        phy_interrupt_in [*3];
    endsequence

    sequence s_rmii_byte_end;
        st_q.mode == MODE_RMII && link_rise && st_q.rxctl_s[1] && st_q.rx_idx == 2'h3;
    endsequence

    a_tx_clock_tick: assert property ( // RQ2
        $changed(mac_tx_clock_pin) |-> $past(link_tick) && $past(st_q.link_cnt) == LINK_LAST)
        else $error("transmit clock moved off divider tick");

    a_ref_clock_rmii: assert property ( // RQ3
        (mode_is_rmii && link_tick) |=> $changed(mac_tx_clock_pin))
        else $error("reference clock missed a tick");

    a_ctl_both_edges: assert property ( // RQ4
        (!mode_is_rmii && $changed(mac_tx_control_pin)) |-> $changed(mac_tx_clock_pin))
        else $error("rgmii control moved off a clock edge");

    a_txen_ref_fall: assert property ( // RQ5
        (mode_is_rmii && $past(mode_is_rmii) && $changed(mac_tx_control_pin))
        |-> $fell(mac_tx_clock_pin))
        else $error("rmii enable not aligned to reference fall");

    a_rmii_upper_zero: assert property ( // RQ10
        (mode_is_rmii && $past(mode_is_rmii))
        |-> !mac_tx_data_bit2 && !mac_tx_data_bit3)
        else $error("upper transmit bits driven in rmii");

    a_rgmii_rx_pair: assert property ( // RQ7
        (!mode_is_rmii && rxc_fall && st_q.rx_dv_lo) |=> rx_valid && rx_data[3:0] == $past(st_q.rx_lo))
        else $error("rgmii byte not assembled on receive fall");

    a_rmii_rx_dibits: assert property ( // RQ11
        s_rmii_byte_end |=> rx_valid && !rx_err)
        else $error("rmii byte not completed after four dibits");

    a_irq_pending: assert property ( // RQ12
        s_irq_held |=> ##1 phy_irq_pending)
        else $error("held interrupt input not seen as pending");

    a_mdc_divider: assert property ( // RQ13
        $changed(mgmt_clock_pin) |-> $past(st_q.mdc_cnt) == MDC_LAST)
        else $error("management clock moved off divider tick");

    a_mdio_release: assert property ( // RQ14
        (st_q.mg == MG_RUN && st_q.mg_read && st_q.mg_bit > `MDIO_TA_BIT) |-> mgmt_data_oe_n)
        else $error("management line driven during read");

    a_mode_when_idle: assert property ( // RQ15
        $changed(st_q.mode) |-> $past(port_idle))
        else $error("link mode changed while busy");

endmodule : eth_phy_port

`default_nettype wire

// file: eth_phy_model.sv
`timescale 1ns/1ns
`default_nettype none

module eth_phy_model (
    // Management
    input wire logic mdc,
    input wire logic mdio,
    input wire logic mac_oe_n,
    input wire logic ref_clk,
    output logic drv_en,
    output logic drv,
    // Receive and interrupt
    output logic rxc,
    output logic rxctl,
    output logic [3:0] rxd,
    output logic irq
);
    logic [63:0] sh = '0;
    logic [63:0] frame = '0;
    logic [5:0] cnt = '0;
    logic rd = 1'b0;
    logic oe_bad = 1'b0;
    logic [15:0] rdata = 16'h0000;

    initial begin
        drv_en = 1'b0;
        drv = 1'b0;
        rxc = 1'b0;
        rxctl = 1'b0;
        rxd = 4'h0;
        irq = 1'b0;
    end

    // ======================================================
    // Management slave
    always @(posedge mdc) begin
        sh = {sh[62:0], mdio};
        if (cnt != 6'd0) cnt = cnt + 6'd1;
        else if (sh[33:0] == {32'hffff_ffff, 2'b01}) cnt = 6'd1;
        if (cnt == 6'd3) rd = (sh[1:0] == 2'b10);
        if (rd && cnt >= 6'd14 && mac_oe_n !== 1'b1) oe_bad = 1'b1;
        if (cnt == 6'd31) begin
            frame = sh;
            cnt = 6'd0;
            rd = 1'b0;
        end
    end

    always @(negedge mdc) begin
        drv_en = rd && cnt >= 6'd14 && cnt <= 6'd30;
        drv = (cnt == 6'd14) ? 1'b0 : rdata[6'd30 - cnt];
    end

    // ======================================================
    // Receive side
    // clock with nibbles
    task automatic send_rgmii(input logic [7:0] b, input logic err);
        rxctl = 1'b1;
        rxd = b[3:0];
        #40 rxc = 1'b1;
        #40 rxctl = ~err;
        rxd = b[7:4];
        #40 rxc = 1'b0;
        #40;
    endtask : send_rgmii

    task automatic end_rgmii;
        rxctl = 1'b0;
        #40 rxc = 1'b1;
        #80 rxc = 1'b0;
        rxd = ~rxd;
    endtask : end_rgmii

    task automatic send_rmii(input logic [7:0] b);
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk);
            rxctl = 1'b1;
            rxd = {2'b00, b[2*i +: 2]};
        end
        @(negedge ref_clk);
        rxctl = 1'b0;
        rxd = ~rxd;
    endtask : send_rmii

    task automatic set_irq(input logic v);
        irq = v;
    endtask : set_irq
endmodule : eth_phy_model

`default_nettype wire

// file: tb_eth_phy_port.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_eth_phy_port;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic m_start = 1'b0;
    logic m_read = 1'b0;
    logic [4:0] m_pa = 5'h00;
    logic [4:0] m_ra = 5'h00;
    logic [15:0] m_wd = 16'h0000;
    logic is_rmii, tx_ready, rx_valid, rx_err, rx_active, busy, done;
    logic txc, txctl, mdc, mdo, oe_n, irq_pend, supply;
    logic rxc, rxctl, irq, drv_en, drv, txc_q, full_seen;
    logic [7:0] rx_data, acc;
    logic [15:0] rdata;
    logic [3:0] txd, rxd, lo;
    wire mdio;
    int failures = 0;
    int n_checks = 0;
    int nd = 0;
    logic [8:0] rx_q[$];
    logic [7:0] tx_q[$];

    assign mdio = !oe_n ? mdo : (drv_en ? drv : 1'b1);
    always #4 clk_sys = ~clk_sys;

    eth_phy_port #(.LINK_HALF(4), .MDC_HALF(4)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .mode_rmii_sel(sel), .mode_is_rmii(is_rmii),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_err(rx_err), .rx_active(rx_active),
        .mgmt_start(m_start), .mgmt_read(m_read), .mgmt_phy_addr(m_pa),
        .mgmt_reg_addr(m_ra), .mgmt_wdata(m_wd), .mgmt_rdata(rdata), .mgmt_busy(busy),
        .mgmt_done(done), .mac_tx_clock_pin(txc), .mac_tx_control_pin(txctl),
        .mac_tx_data_bit0(txd[0]), .mac_tx_data_bit1(txd[1]), .mac_tx_data_bit2(txd[2]),
        .mac_tx_data_bit3(txd[3]), .phy_rx_clock_pin(rxc), .phy_rx_control_pin(rxctl),
        .phy_rx_data_bit0(rxd[0]), .phy_rx_data_bit1(rxd[1]), .phy_rx_data_bit2(rxd[2]),
        .phy_rx_data_bit3(rxd[3]), .mgmt_clock_pin(mdc), .mgmt_data_in(mdio),
        .mgmt_data_out(mdo), .mgmt_data_oe_n(oe_n), .phy_interrupt_in(irq),
        .phy_irq_pending(irq_pend), .port_supply_out(supply));

    eth_phy_model i_phy (
        .mdc(mdc), .mdio(mdio), .mac_oe_n(oe_n), .ref_clk(txc), .drv_en(drv_en),
        .drv(drv), .rxc(rxc), .rxctl(rxctl), .rxd(rxd), .irq(irq));

    // ======================================================
    // Pin monitors
    always @(posedge clk_sys) begin
        if (rx_valid === 1'b1) rx_q.push_back({rx_err, rx_data});
        if (txc_q !== txc && txctl === 1'b1) begin
            if (is_rmii === 1'b0) begin
                if (txc) lo = txd;
                else tx_q.push_back({txd, lo});
            end else if (!txc) begin
                `CHK(txd[3:2], 2'b00)
                acc = {txd[1:0], acc[7:2]};
                nd++;
                if (nd == 4) begin
                    tx_q.push_back(acc);
                    nd = 0;
                end
            end
        end
        txc_q = txc;
    end

    // ======================================================
    // Helpers and scenarios
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic push(input logic [7:0] b);
        tx_valid = 1'b1;
        tx_data = b;
        do begin
            @(posedge clk_sys);
            if (tx_ready !== 1'b1) full_seen = 1'b1;
        end while (tx_ready !== 1'b1);
        #1;
    endtask : push

    task automatic test_reset;
        `CHK(tx_ready, 1'b1)
        `CHK(oe_n, 1'b1)
        `CHK(is_rmii, 1'b0)
        `CHK(supply, 1'b1)
    endtask : test_reset

    task automatic test_irq;
        i_phy.set_irq(1'b1);
        repeat (2) tick;
        `CHK(irq_pend, 1'b0)
        tick;
        `CHK(irq_pend, 1'b1)
        i_phy.set_irq(1'b0);
        repeat (3) tick;
        `CHK(irq_pend, 1'b0)
    endtask : test_irq

    task automatic test_rx_rgmii;
        rx_q.delete();
        i_phy.send_rgmii(8'ha5, 1'b0);
        i_phy.send_rgmii(8'h3c, 1'b1);
        i_phy.end_rgmii();
        repeat (10) tick;
        `CHK(rx_q[0], 9'h0a5)
        `CHK(rx_q[1], 9'h13c)
        `CHK(rx_active, 1'b0)
    endtask : test_rx_rgmii

    task automatic test_tx_rgmii;
        full_seen = 1'b0;
        tx_q.delete();
        for (int i = 0; i < 12; i++) push(8'h10 + 8'(i));
        tx_valid = 1'b0;
        for (int k = 0; k < 400 && tx_q.size() < 12; k++) tick;
        repeat (20) tick;
        `CHK(full_seen, 1'b1)
        for (int i = 0; i < 12; i++) `CHK(tx_q[i], 8'h10 + 8'(i))
        `CHK(txctl, 1'b0)
    endtask : test_tx_rgmii

    task automatic mgmt_cmd(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                            input logic [15:0] wd);
        m_read = rd;
        m_pa = pa;
        m_ra = ra;
        m_wd = wd;
        m_start = 1'b1;
        tick;
        m_start = 1'b0;
        `CHK(busy, 1'b1)
        for (int k = 0; k < 2000 && done !== 1'b1; k++) tick;
        `CHK(done, 1'b1)
    endtask : mgmt_cmd

    task automatic test_mgmt;
        mgmt_cmd(1'b0, 5'h13, 5'h0a, 16'hc35a);
        `CHK(i_phy.frame, {32'hffff_ffff, 4'h5, 5'h13, 5'h0a, 2'b10, 16'hc35a})
        i_phy.rdata = 16'h9e61;
        mgmt_cmd(1'b1, 5'h05, 5'h1f, 16'h0000);
        `CHK(i_phy.frame[63:18], {32'hffff_ffff, 4'h6, 5'h05, 5'h1f})
        `CHK(rdata, 16'h9e61)
        `CHK(i_phy.oe_bad, 1'b0)
    endtask : test_mgmt

    task automatic test_rmii;
        sel = 1'b1;
        repeat (4) tick;
        `CHK(is_rmii, 1'b1)
        tx_q.delete();
        nd = 0;
        push(8'h96);
        push(8'h4b);
        tx_valid = 1'b0;
        for (int k = 0; k < 400 && tx_q.size() < 2; k++) tick;
        `CHK(tx_q[0], 8'h96)
        `CHK(tx_q[1], 8'h4b)
        rx_q.delete();
        i_phy.send_rmii(8'hd2);
        repeat (20) tick;
        `CHK(rx_q[0][7:0], 8'hd2)
    endtask : test_rmii

    task automatic stop_test;
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (10) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        test_reset();
        test_irq();
        test_rx_rgmii();
        test_tx_rgmii();
        test_mgmt();
        test_rmii();
        stop_test();
    end

    initial begin
        #400000;
        failures++;
        stop_test();
    end
endmodule : tb_eth_phy_port

`default_nettype wire
